//--- common/hrcaf_defines.svh
/*
  Offsets, field positions and reset values of the receive command and
  address filter block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef HRCAF_DEFINES_SVH
`define HRCAF_DEFINES_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define HRCAF_IDX_RXCMD      7'h1a
`define HRCAF_IDX_ADDR_DATA  7'h1e
`define HRCAF_IDX_FILL       7'h20
`define HRCAF_IDX_IRQ_STAT   7'h40
`define HRCAF_IDX_IRQ_MASK   7'h41

// ----------------------------------------------------------------
// Receive command port fields
// ----------------------------------------------------------------
`define HRCAF_CMD_CH_HI      15
`define HRCAF_CMD_CH_LO      11
`define HRCAF_CMD_READ       10
`define HRCAF_CMD_SECOND_BYTE_BROADCAST_CHECK       9
`define HRCAF_CMD_SECOND_BYTE_PROGRAMMED_CHECK       8
`define HRCAF_CMD_FIRST_BYTE_BROADCAST_CHECK       7
`define HRCAF_CMD_FIRST_BYTE_PROGRAMMED_CHECK       6
`define HRCAF_CMD_CRC        5
`define HRCAF_CMD_FM         4
`define HRCAF_CMD_P_HI       3
`define HRCAF_CMD_P_LO       2
`define HRCAF_CMD_C_HI       1
`define HRCAF_CMD_C_LO       0

// ----------------------------------------------------------------
// Address data port fields
// ----------------------------------------------------------------
`define HRCAF_AD_CH_HI       20
`define HRCAF_AD_CH_LO       16
`define HRCAF_AD_MASK_SEL    24
`define HRCAF_AD_READ        25

// ----------------------------------------------------------------
// Reset values and the all-ones broadcast byte
// ----------------------------------------------------------------
`define HRCAF_RST_RXCMD      16'h0000
`define HRCAF_RST_ADDR_DATA  32'h0000_0001
`define HRCAF_RST_FILL       8'h00
`define HRCAF_RST_IRQ_MASK   32'h0000_0000
`define HRCAF_ALL_ONES_BYTE  8'hff

`endif

//--- common/hrcaf_pkg.sv
/*
  Types of the receive command and address filter block.
  Assumes nothing of its surroundings.
*/
package hrcaf_pkg;

  typedef enum logic [1:0] {
    HRCAF_CMD_ABORT    = 2'h0,
    HRCAF_CMD_START    = 2'h1,
    HRCAF_CMD_CONTINUE = 2'h2,
    HRCAF_CMD_HALT     = 2'h3
  } hrcaf_cmd_e;

  typedef enum logic [1:0] {
    HRCAF_PROTO_HDLC   = 2'h0,
    HRCAF_PROTO_TFILL  = 2'h1,
    HRCAF_PROTO_TRAW   = 2'h2,
    HRCAF_PROTO_RSVD   = 2'h3
  } hrcaf_proto_e;

  typedef enum logic [1:0] {
    HRCAF_EV_NONE      = 2'h0,
    HRCAF_EV_OPEN      = 2'h1,
    HRCAF_EV_DATA      = 2'h3,
    HRCAF_EV_CLOSE     = 2'h2
  } hrcaf_ev_e;

  typedef logic [4:0] hrcaf_chan_t;

endpackage

//--- verilog/hrcaf_rx_filter.sv
/*
  Receive command memory and address field filter for 32 receive channels
  (HDLC, transparent fill or raw), with an Avalon-MM register slave and a level interrupt.
  Assumes the frame stream comes from logic on clk, one event per cycle,
  already deserialised to bytes with flags marked as open and close.
*/
`timescale 1ns/10ps
`include "hrcaf_defines.svh"

module hrcaf_rx_filter (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  strm_event,
  input  wire logic [4:0]  strm_chan,
  input  wire logic [7:0]  strm_byte,
  input  wire logic        strm_crc,
  output logic             out_valid,
  output logic      [4:0]  out_chan,
  output logic      [15:0] out_data,
  output logic      [1:0]  out_nbytes,
  output logic             out_eom,
  output logic             dma_req_valid,
  output logic      [4:0]  dma_req_chan,
  output logic      [1:0]  dma_req_code,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Per-channel storage
  // ----------------------------------------------------------------
  logic [9:0]  cfg_mem   [32];
  logic        fm_mem    [32];
  logic        run_mem   [32];
  logic        hpend_mem [32];
  logic        infr_mem  [32];
  logic        disc_mem  [32];
  logic [1:0]  cnt_mem   [32];
  logic [7:0]  b1_mem    [32];
  logic [15:0] exp_mem   [32];
  logic [15:0] msk_mem   [32];

  logic [15:0] rxcmd_r;
  logic [31:0] addr_r;
  logic [7:0]  fill_r;
  logic [31:0] irq_stat_r;
  logic [31:0] irq_mask_r;
  logic [31:0] rd_snap_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic byte_pass(input logic [7:0] b, input logic [7:0] expv,
                                     input logic [7:0] msk, input logic en_prog,
                                     input logic en_bc);
    logic prog_ok;
    logic bc_ok;
    prog_ok = (((b ^ expv) & ~msk) == 8'h00);
    bc_ok   = (b == `HRCAF_ALL_ONES_BYTE);
    if (!en_prog && !en_bc) begin
      byte_pass = 1'b1;
    end else begin
      byte_pass = (en_prog && prog_ok) || (en_bc && bc_ok);
    end
  endfunction

  function automatic logic [31:0] chan_bit(input logic [4:0] c);
    chan_bit = 32'h0000_0001 << c;
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM handshake: one wait cycle, then accept
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_acc;
  logic wr_acc;
  logic rd_acc;
  logic lo_be;
  logic all_be;

  assign bus_req = avs_read || avs_write;
  assign bus_acc = bus_req && !avs_waitrequest;
  assign wr_acc  = bus_acc && avs_write;
  assign rd_acc  = bus_acc && avs_read;
  assign lo_be   = &avs_byteenable[1:0];
  assign all_be  = &avs_byteenable;

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      case (avs_address)
        `HRCAF_IDX_RXCMD:     avs_readdata <= {16'h0000, rxcmd_r};
        `HRCAF_IDX_ADDR_DATA: avs_readdata <= addr_r;
        `HRCAF_IDX_FILL:      avs_readdata <= {24'h000000, fill_r};
        `HRCAF_IDX_IRQ_STAT:  avs_readdata <= irq_stat_r;
        `HRCAF_IDX_IRQ_MASK:  avs_readdata <= irq_mask_r;
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Snapshot of status bits returned, so only those are cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_snap_r <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      rd_snap_r <= (avs_address == `HRCAF_IDX_IRQ_STAT) ? irq_stat_r : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Command port decode
  // ----------------------------------------------------------------
  logic       cmd_wr;
  logic       cmd_rd_dir;
  logic [4:0] cmd_ch;
  logic [1:0] cmd_code;

  assign cmd_wr     = wr_acc && lo_be && (avs_address == `HRCAF_IDX_RXCMD);
  assign cmd_rd_dir = avs_writedata[`HRCAF_CMD_READ];
  assign cmd_ch     = avs_writedata[`HRCAF_CMD_CH_HI:`HRCAF_CMD_CH_LO];
  assign cmd_code   = avs_writedata[`HRCAF_CMD_C_HI:`HRCAF_CMD_C_LO];

  always_ff @(posedge clk) begin
    if (srst) begin
      rxcmd_r <= `HRCAF_RST_RXCMD;
    end else if (ce && cmd_wr) begin
      if (cmd_rd_dir) begin
        rxcmd_r <= {cmd_ch, 1'b1, cfg_mem[cmd_ch][9:5], fm_mem[cmd_ch],
                    cfg_mem[cmd_ch][3:0]};
      end else begin
        rxcmd_r <= avs_writedata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Address data port and fill character
  // ----------------------------------------------------------------
  logic       ad_wr;
  logic [4:0] ad_ch;

  assign ad_wr = wr_acc && all_be && (avs_address == `HRCAF_IDX_ADDR_DATA);
  assign ad_ch = avs_writedata[`HRCAF_AD_CH_HI:`HRCAF_AD_CH_LO];

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_r <= `HRCAF_RST_ADDR_DATA;
      for (int i = 0; i < 32; i++) begin
        exp_mem[i] <= 16'h0000;
        msk_mem[i] <= 16'h0000;
      end
    end else if (ce && ad_wr) begin
      if (avs_writedata[`HRCAF_AD_READ]) begin
        addr_r <= {avs_writedata[31:16], avs_writedata[`HRCAF_AD_MASK_SEL] ?
                   msk_mem[ad_ch] : exp_mem[ad_ch]};
      end else begin
        addr_r <= avs_writedata;
        if (avs_writedata[`HRCAF_AD_MASK_SEL]) begin
          msk_mem[ad_ch] <= avs_writedata[15:0];
        end else begin
          exp_mem[ad_ch] <= avs_writedata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fill_r <= `HRCAF_RST_FILL;
    end else if (ce && wr_acc && avs_byteenable[0] && (avs_address == `HRCAF_IDX_FILL)) begin
      fill_r <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Stream channel view and next state
  // ----------------------------------------------------------------
  logic [9:0]  s_cfg;
  logic [1:0]  s_proto;
  logic        s_run;
  logic        s_infr;
  logic        s_disc;
  logic [1:0]  s_cnt;
  logic [7:0]  s_b1;
  logic        s_pass1;
  logic        s_pass2;
  logic        s_chk2;
  logic        s_flag;
  logic        s_infr_nxt;
  logic        s_disc_nxt;
  logic [1:0]  s_cnt_nxt;
  logic        s_stop;
  logic        o_valid_nxt;
  logic [15:0] o_data_nxt;
  logic [1:0]  o_n_nxt;
  logic        o_eom_nxt;

  assign s_cfg   = cfg_mem[strm_chan];
  assign s_proto = s_cfg[`HRCAF_CMD_P_HI:`HRCAF_CMD_P_LO];
  assign s_run   = run_mem[strm_chan];
  assign s_infr  = infr_mem[strm_chan];
  assign s_disc  = disc_mem[strm_chan];
  assign s_cnt   = cnt_mem[strm_chan];
  assign s_b1    = b1_mem[strm_chan];
  assign s_chk2  = s_cfg[`HRCAF_CMD_SECOND_BYTE_PROGRAMMED_CHECK] || s_cfg[`HRCAF_CMD_SECOND_BYTE_BROADCAST_CHECK];
  assign s_pass1 = byte_pass(strm_byte, exp_mem[strm_chan][7:0], msk_mem[strm_chan][7:0],
                             s_cfg[`HRCAF_CMD_FIRST_BYTE_PROGRAMMED_CHECK], s_cfg[`HRCAF_CMD_FIRST_BYTE_BROADCAST_CHECK]);
  assign s_pass2 = byte_pass(strm_byte, exp_mem[strm_chan][15:8], msk_mem[strm_chan][15:8],
                             s_cfg[`HRCAF_CMD_SECOND_BYTE_PROGRAMMED_CHECK], s_cfg[`HRCAF_CMD_SECOND_BYTE_BROADCAST_CHECK]);
  assign s_flag  = (strm_event == hrcaf_pkg::HRCAF_EV_OPEN) || (strm_event == hrcaf_pkg::HRCAF_EV_CLOSE);

  always_comb begin
    s_infr_nxt  = s_infr;
    s_disc_nxt  = s_disc;
    s_cnt_nxt   = s_cnt;
    s_stop      = 1'b0;
    o_valid_nxt = 1'b0;
    o_data_nxt  = 16'h0000;
    o_n_nxt     = 2'h0;
    o_eom_nxt   = 1'b0;
    case (strm_event)
      hrcaf_pkg::HRCAF_EV_OPEN: begin
        if (s_run && (s_proto == hrcaf_pkg::HRCAF_PROTO_HDLC)) begin
          s_infr_nxt = 1'b1;
          s_disc_nxt = 1'b0;
          s_cnt_nxt  = 2'h0;
        end
      end
      hrcaf_pkg::HRCAF_EV_DATA: begin
        if (s_run) begin
          case (s_proto)
            hrcaf_pkg::HRCAF_PROTO_HDLC: begin
              if (s_infr && !s_disc && !(strm_crc && !s_cfg[`HRCAF_CMD_CRC])) begin
                case (s_cnt)
                  2'h0: begin
                    s_cnt_nxt  = 2'h1;
                    s_disc_nxt = !s_pass1;
                  end
                  2'h1: begin
                    s_cnt_nxt   = 2'h2;
                    s_disc_nxt  = !s_pass2;
                    o_valid_nxt = s_pass2;
                    o_data_nxt  = {strm_byte, s_b1};
                    o_n_nxt     = 2'h2;
                  end
                  default: begin
                    o_valid_nxt = 1'b1;
                    o_data_nxt  = {8'h00, strm_byte};
                    o_n_nxt     = 2'h1;
                  end
                endcase
              end
            end
            hrcaf_pkg::HRCAF_PROTO_TFILL: begin
              if (strm_byte == fill_r) begin
                o_valid_nxt = s_infr;
                o_eom_nxt   = s_infr;
                s_infr_nxt  = 1'b0;
              end else begin
                o_valid_nxt = 1'b1;
                o_data_nxt  = {8'h00, strm_byte};
                o_n_nxt     = 2'h1;
                s_infr_nxt  = 1'b1;
              end
            end
            hrcaf_pkg::HRCAF_PROTO_TRAW: begin
              o_valid_nxt = 1'b1;
              o_data_nxt  = {8'h00, strm_byte};
              o_n_nxt     = 2'h1;
            end
            default: begin
              o_valid_nxt = 1'b0;
            end
          endcase
        end
      end
      hrcaf_pkg::HRCAF_EV_CLOSE: begin
        if (s_infr && (s_proto == hrcaf_pkg::HRCAF_PROTO_HDLC)) begin
          s_infr_nxt = 1'b0;
          s_stop     = hpend_mem[strm_chan];
          if (!s_disc && (s_cnt == 2'h1) && !s_chk2) begin
            o_valid_nxt = 1'b1;
            o_data_nxt  = {8'h00, s_b1};
            o_n_nxt     = 2'h1;
            o_eom_nxt   = 1'b1;
          end else if (!s_disc && (s_cnt == 2'h2)) begin
            o_valid_nxt = 1'b1;
            o_eom_nxt   = 1'b1;
          end
        end
      end
      default: begin
        s_stop = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Channel state update: stream first, command on top
  // ----------------------------------------------------------------
  logic cmd_act;
  logic cmd_same;
  logic cmd_infr;
  logic cmd_irq;

  assign cmd_act  = cmd_wr && !cmd_rd_dir;
  assign cmd_same = (strm_event != hrcaf_pkg::HRCAF_EV_NONE) && (strm_chan == cmd_ch);
  assign cmd_infr = cmd_same ? s_infr_nxt : infr_mem[cmd_ch];
  assign cmd_irq  = cmd_act && ((cmd_code == hrcaf_pkg::HRCAF_CMD_ABORT) ||
                    ((cmd_code == hrcaf_pkg::HRCAF_CMD_HALT) && !cmd_infr));

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        run_mem[i]   <= 1'b0;
        hpend_mem[i] <= 1'b0;
        infr_mem[i]  <= 1'b0;
        disc_mem[i]  <= 1'b0;
        cnt_mem[i]   <= 2'h0;
        b1_mem[i]    <= 8'h00;
      end
    end else if (ce) begin
      if (strm_event != hrcaf_pkg::HRCAF_EV_NONE) begin
        infr_mem[strm_chan] <= s_infr_nxt;
        disc_mem[strm_chan] <= s_disc_nxt;
        cnt_mem[strm_chan]  <= s_cnt_nxt;
        if ((strm_event == hrcaf_pkg::HRCAF_EV_DATA) && (s_cnt == 2'h0)) begin
          b1_mem[strm_chan] <= strm_byte;
        end
        if (s_stop) begin
          run_mem[strm_chan]   <= 1'b0;
          hpend_mem[strm_chan] <= 1'b0;
        end
      end
      if (cmd_act) begin
        case (cmd_code)
          hrcaf_pkg::HRCAF_CMD_ABORT: begin
            run_mem[cmd_ch]   <= 1'b0;
            hpend_mem[cmd_ch] <= 1'b0;
            infr_mem[cmd_ch]  <= 1'b0;
          end
          hrcaf_pkg::HRCAF_CMD_START, hrcaf_pkg::HRCAF_CMD_CONTINUE: begin
            run_mem[cmd_ch]   <= 1'b1;
            hpend_mem[cmd_ch] <= 1'b0;
          end
          default: begin
            hpend_mem[cmd_ch] <= cmd_infr;
            if (!cmd_infr) begin
              run_mem[cmd_ch] <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Entry store; flag status only cleared by software, set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        cfg_mem[i] <= 10'h000;
        fm_mem[i]  <= 1'b0;
      end
    end else if (ce) begin
      if (cmd_act) begin
        cfg_mem[cmd_ch] <= avs_writedata[9:0];
        if (!avs_writedata[`HRCAF_CMD_FM]) begin
          fm_mem[cmd_ch] <= 1'b0;
        end
      end
      if (s_flag || ((strm_event == hrcaf_pkg::HRCAF_EV_DATA) && s_infr)) begin
        fm_mem[strm_chan] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stream output and DMA request
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid  <= 1'b0;
      out_chan   <= 5'h00;
      out_data   <= 16'h0000;
      out_nbytes <= 2'h0;
      out_eom    <= 1'b0;
    end else if (ce) begin
      out_valid  <= o_valid_nxt;
      out_chan   <= strm_chan;
      out_data   <= o_data_nxt;
      out_nbytes <= o_n_nxt;
      out_eom    <= o_eom_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dma_req_valid <= 1'b0;
      dma_req_chan  <= 5'h00;
      dma_req_code  <= 2'h0;
    end else if (ce) begin
      dma_req_valid <= cmd_act && ((cmd_code == hrcaf_pkg::HRCAF_CMD_START) ||
                       (cmd_code == hrcaf_pkg::HRCAF_CMD_CONTINUE));
      dma_req_chan  <= cmd_ch;
      dma_req_code  <= cmd_code;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  logic [31:0] irq_set;

  assign irq_set = (cmd_irq ? chan_bit(cmd_ch) : 32'h0000_0000) |
                   ((ce && s_stop) ? chan_bit(strm_chan) : 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_r <= 32'h0000_0000;
    end else if (ce) begin
      irq_stat_r <= (irq_stat_r & ~((rd_acc && (avs_address == `HRCAF_IDX_IRQ_STAT)) ?
                     rd_snap_r : 32'h0000_0000)) | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask_r <= `HRCAF_RST_IRQ_MASK;
    end else if (ce && wr_acc && all_be && (avs_address == `HRCAF_IDX_IRQ_MASK)) begin
      irq_mask_r <= avs_writedata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

//--- verif/hrcaf_rx_filter_monitor.sv
/*
  Port checker of the receive command and address filter.
  Assumes ce and all byte lanes held high by the bench.
*/
`timescale 1ns/10ps
`include "hrcaf_defines.svh"
module hrcaf_rx_filter_mon (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  strm_event,
  input wire logic [7:0]  strm_byte,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic [1:0]  out_nbytes,
  input wire logic        out_eom,
  input wire logic        dma_req_valid,
  input wire logic [4:0]  dma_req_chan,
  input wire logic [1:0]  dma_req_code
);
  // ------------------------------------------------------------
  // Helper state and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic acc = !avs_waitrequest && (avs_read || avs_write);
  logic        go_r;
  logic [15:0] wd_r;
  always_ff @(posedge clk) begin
    go_r <= !srst && acc && avs_write && avs_address == `HRCAF_IDX_RXCMD && !avs_writedata[10]
            && (avs_writedata[1:0] == 2'h1 || avs_writedata[1:0] == 2'h2);
    wd_r <= avs_writedata[15:0];
  end
  property p_wait_once; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_once: assert property (p_wait_once) else $error("waitrequest not low after request");
  property p_wait_short; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_short: assert property (p_wait_short) else $error("waitrequest low two cycles");
  property p_unmapped; acc && avs_read && !(avs_address inside {`HRCAF_IDX_RXCMD, `HRCAF_IDX_ADDR_DATA,
    `HRCAF_IDX_FILL, `HRCAF_IDX_IRQ_STAT, `HRCAF_IDX_IRQ_MASK}) |-> avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cmd_hi; acc && avs_read && avs_address == `HRCAF_IDX_RXCMD |-> avs_readdata[31:16] == 16'h0;
  endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("command port upper half not zero");
  property p_dma; go_r |-> dma_req_valid && dma_req_chan == wd_r[15:11] && dma_req_code == wd_r[1:0];
  endproperty
  a_dma: assert property (p_dma) else $error("dma request wrong or missing");
  property p_dma_cause; dma_req_valid |-> go_r; endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma request without command");
  property p_eom; out_valid && out_nbytes == 2'h0 |-> out_eom; endproperty
  a_eom: assert property (p_eom) else $error("empty output without end");
  property p_cause; out_valid |-> $past(strm_event) != 2'h0; endproperty
  a_cause: assert property (p_cause) else $error("output without stream event");
  property p_pair; out_valid && out_nbytes == 2'h2 |-> out_data[15:8] == $past(strm_byte); endproperty
  a_pair: assert property (p_pair) else $error("second byte of pair wrong");
  property p_one; out_valid && out_nbytes == 2'h1 && !out_eom |-> out_data[7:0] == $past(strm_byte);
  endproperty
  a_one: assert property (p_one) else $error("single byte wrong");
endmodule
bind hrcaf_rx_filter hrcaf_rx_filter_mon i_hrcaf_rx_filter_mon (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .strm_event, .strm_byte, .out_valid,
  .out_data, .out_nbytes, .out_eom, .dma_req_valid, .dma_req_chan, .dma_req_code);

//--- verif/hrcaf_tdm_src.sv
/*
  Model of the multiplex side: frames of bytes for one channel.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/10ps
module hrcaf_tdm_src (
  input  wire logic       clk,
  output logic      [1:0] strm_event,
  output logic      [4:0] strm_chan,
  output logic      [7:0] strm_byte,
  output logic            strm_crc
);
  // ------------------------------------------------------------
  // Event driver
  // ------------------------------------------------------------
  initial {strm_event, strm_chan, strm_byte, strm_crc} = 16'h005a;
  task automatic put(input logic [4:0] ch, input logic [1:0] ev, input logic [7:0] b, input logic c);
    @(posedge clk);
    strm_chan  <= ch;
    strm_event <= ev;
    strm_byte  <= b;
    strm_crc   <= c;
  endtask
  // Idle byte is the inverse of the last one
  task automatic send(input logic [4:0] ch, input logic [7:0] q[$], input int ncrc);
    put(ch, hrcaf_pkg::HRCAF_EV_OPEN, ~strm_byte, 1'b0);
    foreach (q[i]) put(ch, hrcaf_pkg::HRCAF_EV_DATA, q[i], i >= q.size() - ncrc);
    put(ch, hrcaf_pkg::HRCAF_EV_CLOSE, ~strm_byte, 1'b0);
    put(ch, hrcaf_pkg::HRCAF_EV_NONE, ~strm_byte, 1'b0);
  endtask
endmodule

//--- verif/hrcaf_rx_filter_bench.sv
/*
  Self-checking bench of the receive filter.
  Assumes the multiplex model and the bound port checker.
*/
`timescale 1ns/10ps
`include "hrcaf_defines.svh"
module hrcaf_rx_filter_bench;
  logic        clk, srst, avs_read, avs_write, avs_waitrequest, irq, out_valid, out_eom, dma_req_valid;
  logic        strm_crc;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  strm_event, out_nbytes, dma_req_code;
  logic [4:0]  strm_chan, out_chan, dma_req_chan;
  logic [7:0]  strm_byte;
  logic [15:0] out_data;
  logic [23:0] got_q[$];
  int          num_errors, total_checks, n;
  // ------------------------------------------------------------
  // Clock, instances, output capture
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  hrcaf_rx_filter i_hrcaf_rx_filter (.clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .strm_event, .strm_chan,
    .strm_byte, .strm_crc, .out_valid, .out_chan, .out_data, .out_nbytes, .out_eom, .dma_req_valid,
    .dma_req_chan, .dma_req_code, .irq);
  hrcaf_tdm_src i_hrcaf_tdm_src (.clk, .strm_event, .strm_chan, .strm_byte, .strm_crc);
  always @(posedge clk) if (out_valid) got_q.push_back({out_eom, out_nbytes, out_chan,
    out_nbytes == 2'h2 ? out_data : (out_nbytes == 2'h1 ? {8'h0, out_data[7:0]} : 16'h0)});
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask
  task automatic out(input logic [23:0] w);
    repeat (2) @(posedge clk);
    rd = 32'hffffffff;
    if (got_q.size() > 0) rd = {8'h0, got_q.pop_front()};
    chk("output word", {8'h0, w}, rd);
  endtask
  task automatic none();
    repeat (3) @(posedge clk);
    chk("extra outputs", 32'h0, got_q.size());
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    bus(0, `HRCAF_IDX_RXCMD, 0); chk("command port", 32'h0, rd);
    bus(0, `HRCAF_IDX_ADDR_DATA, 0); chk("address data", 32'h1, rd);
    bus(0, 7'h7f, 0); chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_filter();
    bus(1, `HRCAF_IDX_ADDR_DATA, 32'h0003_3412);
    bus(1, `HRCAF_IDX_ADDR_DATA, 32'h0103_0001);
    bus(1, `HRCAF_IDX_RXCMD, 32'h1941);
    i_hrcaf_tdm_src.send(3, '{8'h13, 8'h34, 8'h56, 8'haa}, 1);
    out(24'h433413);
    out(24'h230056);
    out(24'h800000 | 24'h3_0000);
    i_hrcaf_tdm_src.send(3, '{8'h12, 8'h35, 8'h77}, 0);
    i_hrcaf_tdm_src.send(3, '{8'h10, 8'h34}, 0);
    none();
    bus(1, `HRCAF_IDX_RXCMD, 32'h1c00);
    bus(0, `HRCAF_IDX_RXCMD, 0); chk("read back", 32'h1d51, rd);
  endtask
  task automatic t_abort();
    bus(1, `HRCAF_IDX_IRQ_MASK, 0);
    bus(1, `HRCAF_IDX_RXCMD, 32'h1940); none(); chk("masked irq", 0, irq);
    bus(1, `HRCAF_IDX_IRQ_MASK, 32'h8); none(); chk("irq", 1, irq);
    bus(0, `HRCAF_IDX_IRQ_STAT, 0); chk("status", 32'h8, rd);
    bus(0, `HRCAF_IDX_IRQ_STAT, 0); chk("status cleared", 0, rd);
    i_hrcaf_tdm_src.send(3, '{8'h13, 8'h34}, 0);
    none(); chk("irq low", 0, irq);
  endtask
  task automatic t_halt();
    bus(1, `HRCAF_IDX_RXCMD, 32'h1a81);
    fork
      i_hrcaf_tdm_src.send(3, '{8'hff, 8'hff, 8'h01}, 0);
      begin
        repeat (2) @(posedge clk);
        bus(1, `HRCAF_IDX_RXCMD, 32'h1a83);
      end
    join
    out(24'h43ffff); out(24'h230001); out(24'h830000);
    bus(0, `HRCAF_IDX_IRQ_STAT, 0); chk("halt status", 32'h8, rd);
    bus(1, `HRCAF_IDX_RXCMD, 32'h1a82);
    i_hrcaf_tdm_src.send(3, '{8'hff, 8'hfe}, 0); none();
    bus(1, `HRCAF_IDX_RXCMD, 32'h1801);
    i_hrcaf_tdm_src.send(3, '{8'h00}, 0); out(24'ha30000);
  endtask
  task automatic t_modes();
    bus(1, `HRCAF_IDX_FILL, 32'h7e);
    bus(1, `HRCAF_IDX_RXCMD, 32'h1805);
    i_hrcaf_tdm_src.put(3, 2'h3, 8'h41, 0);
    i_hrcaf_tdm_src.put(3, 2'h3, 8'h7e, 0);
    i_hrcaf_tdm_src.put(3, 2'h3, 8'h7e, 0);
    i_hrcaf_tdm_src.put(3, 2'h0, 8'h81, 0);
    out(24'h230041); out(24'h830000); none();
    bus(1, `HRCAF_IDX_RXCMD, 32'h1809);
    i_hrcaf_tdm_src.put(3, 2'h3, 8'h7e, 0);
    i_hrcaf_tdm_src.put(3, 2'h0, 8'h81, 0); out(24'h23007e);
    bus(1, `HRCAF_IDX_RXCMD, 32'h180d);
    i_hrcaf_tdm_src.put(3, 2'h3, 8'h7e, 0);
    i_hrcaf_tdm_src.put(3, 2'h0, 8'h81, 0); none();
  endtask
  initial begin
    {srst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 7'h0, 32'h0};
    {num_errors, total_checks} = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_filter();
    t_abort();
    t_halt();
    t_modes();
    test_done();
  end
endmodule
